// ==== shared/pcie_tag_pkg.sv ====
// package: tag codes, client set and timing constants of the request tag and error handler
// Functional notes
// - receive data write tag 00, first descriptor read 01, first write-back 02
// - transmit descriptor read/write-back tags 04/05 first queue, 06/07 second queue
// - transmit data reads use tags 08 to 0b, four concurrent fetches
// - second receive queue descriptor read tag 0c, write-back tag 0e
// - management client reads use tag 10, writes use tag 11
// - start a completion timer when a read request leaves the block
// - timer fires no earlier than 10 ms and no later than 50 ms
// - on timeout report non-fatal error and send the read again
// - split read finished only after its last completion; early data may be dropped
// - completions in any order are released to the core in request order
// - receiver and bad tlp errors raise correctable, nak and drop; bad dllps dropped
// - flow-control init violation by the partner is reported fatal
// - poisoned tlp is non-fatal with header log; poisoned completion blocks its client
// - unsupported request answered with unsupported-request completion, non-fatal
// - flash write while write-enable field is 10b gets completer abort, non-fatal, logged
// - completion with unknown tag or id is discarded, non-fatal, logged
// - tlp beyond advertised credits is reported fatal
// - malformed tlp is fatal, logged, dropped and its credits released
// - unsuccessful completion reports no error but releases its credits
// - receiver error suppresses link and transaction errors of that packet
// - link layer error suppresses transaction errors of that packet
// - after an unsuccessful completion the read is requested again
package pcie_tag_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int CPL_TO_MIN_MS = 10;
	localparam int CPL_TO_MAX_MS = 50;
	localparam int CPL_TO_CYCLES = CPL_TO_MIN_MS * (CLK_HZ / 1000);
	localparam int NUM_CLIENTS = 17;
	localparam int HDR_W = 128;
	localparam logic [1:0] FWE_WRITES_OFF = 2'h2;
	localparam logic [2:0] CPL_ST_UR = 3'h1;
	localparam logic [2:0] CPL_ST_CA = 3'h4;
	localparam logic [4:0] PTR_LAST = 5'h10;
	typedef enum logic [4:0] {
		CL_RX_DATA, CL_RX_DRD0, CL_RX_DWB0, CL_TX_DRD0, CL_TX_DWB0, CL_TX_DRD1, CL_TX_DWB1,
		CL_TX_DAT0, CL_TX_DAT1, CL_TX_DAT2, CL_TX_DAT3, CL_RX_DRD1, CL_RX_DWB1,
		CL_MGMT_RD, CL_MGMT_WR
	} client_t;

	// tag code of each client
	function automatic logic [7:0] client_tag(input logic [4:0] c);
		logic [7:0] t;
		t = 8'h00;
		case (c)
			5'h01: t = 8'h01;
			5'h02: t = 8'h02;
			5'h03: t = 8'h04;
			5'h04: t = 8'h05;
			5'h05: t = 8'h06;
			5'h06: t = 8'h07;
			5'h07: t = 8'h08;
			5'h08: t = 8'h09;
			5'h09: t = 8'h0a;
			5'h0a: t = 8'h0b;
			5'h0b: t = 8'h0c;
			5'h0c: t = 8'h0e;
			5'h0d: t = 8'h10;
			5'h0e: t = 8'h11;
			default: t = 8'h00;
		endcase
		return t;
	endfunction : client_tag

	// clients whose requests expect completions
	function automatic logic client_reads(input logic [4:0] c);
		return c == 5'h01 || c == 5'h03 || c == 5'h05 || (c >= 5'h07 && c <= 5'h0b) || c == 5'h0d;
	endfunction : client_reads
endpackage : pcie_tag_pkg

// ==== shared/ctimer_if.sv ====
// interface: control and expiry of one completion timer
`timescale 1ns/1ps
interface ctimer_if;
	logic start;
	logic stop;
	logic expired;
	modport ctl (output start, output stop, input expired);
	modport tmr (input start, input stop, output expired);
endinterface : ctimer_if

// ==== hw/completion_timer.sv ====
// module: one completion timeout counter
`timescale 1ns/1ps
module completion_timer #(
	parameter int unsigned LIMIT = pcie_tag_pkg::CPL_TO_CYCLES
) (
	input wire logic clk_sys,
	input wire logic srst,
	ctimer_if.tmr tif
);
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic run_reg;
	logic run_next;
	logic at_limit;

	// expiry after exactly limit cycles from the start
	assign at_limit = run_reg && (cnt_reg == 32'(LIMIT - 1));
	assign tif.expired = at_limit && !tif.start && !tif.stop;

	// restart wins over stop, stop over counting
	always_comb begin
		run_next = run_reg;
		cnt_next = cnt_reg;
		if (tif.start) begin
			run_next = 1'b1;
			cnt_next = 32'h0;
		end else if (tif.stop || at_limit) begin
			run_next = 1'b0;
		end else if (run_reg) begin
			cnt_next = cnt_reg + 32'h1;
		end
	end

	// counter state
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			run_reg <= 1'b0;
			cnt_reg <= 32'h0;
		end else begin
			run_reg <= run_next;
			cnt_reg <= cnt_next;
		end
	end

	tmr_start_a: assert property (@(posedge clk_sys) disable iff (srst)
		tif.start |=> run_reg && cnt_reg == 32'h0) else $error("timer did not restart");
	tmr_once_a: assert property (@(posedge clk_sys) disable iff (srst)
		tif.expired |=> !run_reg && !tif.expired) else $error("timer fired twice");
endmodule : completion_timer

// ==== hw/pcie_request_tag_and_error_handler.sv ====
// module: request tagging, completion timeout, in-order release and receive error handling
`timescale 1ns/1ps
module pcie_request_tag_and_error_handler #(
	parameter int unsigned CPL_TO_CYCLES = pcie_tag_pkg::CPL_TO_CYCLES,
	parameter int HDR_W = pcie_tag_pkg::HDR_W
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic req_valid,
	input wire pcie_tag_pkg::client_t req_client,
	output logic req_ready,
	output logic tx_valid,
	output logic [7:0] tx_tag,
	output logic tx_retry,
	input wire logic rx_valid,
	input wire logic [HDR_W-1:0] rx_hdr,
	input wire logic rx_phy_err,
	input wire logic rx_dl_err,
	input wire logic rx_overflow,
	input wire logic rx_malformed,
	input wire logic rx_poisoned,
	input wire logic rx_unsupported,
	input wire logic rx_flash_wr,
	input wire logic rx_is_cpl,
	input wire logic rx_cpl_ok,
	input wire logic rx_cpl_last,
	input wire logic [7:0] rx_tag,
	input wire logic rx_id_match,
	input wire logic [1:0] flash_write_enable_field,
	input wire logic dllp_valid,
	input wire logic dllp_phy_err,
	input wire logic dllp_bad,
	input wire logic fc_init_violation,
	output logic deliver_valid,
	output logic [7:0] deliver_tag,
	output logic err_corr,
	output logic err_nonfatal,
	output logic err_fatal,
	output logic hdr_log_valid,
	output logic [HDR_W-1:0] hdr_log,
	output logic nak,
	output logic tlp_drop,
	output logic dllp_drop,
	output logic fc_release,
	output logic cpl_gen_valid,
	output logic [2:0] cpl_gen_status,
	output logic [pcie_tag_pkg::NUM_CLIENTS-1:0] client_blocked
);
	localparam int N = pcie_tag_pkg::NUM_CLIENTS;

	logic [N-1:0] pend_reg, pend_next;
	logic [N-1:0] done_reg, done_next;
	logic [N-1:0] retry_reg, retry_next;
	logic [N-1:0] block_reg, block_next;
	logic [4:0] oq_reg [N];
	logic [4:0] wr_ptr_reg, rd_ptr_reg;
	logic [5:0] oq_cnt_reg;
	logic tx_valid_reg, tx_retry_reg;
	logic [7:0] tx_tag_reg;
	logic deliver_valid_reg;
	logic [7:0] deliver_tag_reg;
	logic err_corr_reg, err_nonfatal_reg, err_fatal_reg;
	logic hdr_log_valid_reg, nak_reg, tlp_drop_reg, dllp_drop_reg, fc_release_reg;
	logic [HDR_W-1:0] hdr_log_reg;
	logic cpl_gen_valid_reg;
	logic [2:0] cpl_gen_status_reg;

	logic [N-1:0] expire, tmr_start, tmr_stop, tag_hit, issue_vec, clr_retry;
	logic [N-1:0] set_done, set_block, set_retry, pop_vec;
	logic [4:0] retry_sel, issue_client, head;
	logic retry_any, new_ok, issue, issue_reads, pop, head_done, head_block;
	logic tl_ok, dl_err, cpl_known, cpl_unexp, cpl_bad, cpl_good, cpl_poison, any_expire;
	logic ev_fatal, ev_nonfatal, ev_corr, ev_log, ev_ur, ev_ca, ev_fc_free, ev_drop;
	logic [4:0] hit_client;

	// lowest pending retry that may still be sent
	always_comb begin
		retry_sel = 5'h0;
		retry_any = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (retry_reg[i] && !block_reg[i]) begin
				retry_sel = 5'(i);
				retry_any = 1'b1;
			end
		end
	end

	// retries come first; a read client holds one request at a time
	assign new_ok = !block_reg[req_client] && !(pcie_tag_pkg::client_reads(req_client) && pend_reg[req_client]);
	assign req_ready = !retry_any && new_ok && !srst;
	assign issue = retry_any || (req_valid && req_ready);
	assign issue_client = retry_any ? retry_sel : req_client;
	assign issue_reads = pcie_tag_pkg::client_reads(issue_client);

	// completion tag lookup; the completer echoes the request tag
	always_comb begin
		hit_client = 5'h0;
		for (int i = 0; i < N; i++) begin
			if (tag_hit[i]) begin
				hit_client = 5'(i);
			end
		end
	end

	// layered classification of a received packet
	assign dl_err = !rx_phy_err && rx_dl_err;
	assign tl_ok = rx_valid && !rx_phy_err && !rx_dl_err;
	assign cpl_known = |tag_hit && pend_reg[hit_client] && !done_reg[hit_client] && rx_id_match;
	assign cpl_poison = tl_ok && !rx_overflow && !rx_malformed && rx_poisoned;
	assign cpl_unexp = tl_ok && !rx_overflow && !rx_malformed && !rx_poisoned && rx_is_cpl && !cpl_known;
	assign cpl_bad = tl_ok && !rx_overflow && !rx_malformed && !rx_poisoned && rx_is_cpl && cpl_known && !rx_cpl_ok;
	assign cpl_good = tl_ok && !rx_overflow && !rx_malformed && !rx_poisoned && rx_is_cpl && cpl_known && rx_cpl_ok;
	assign ev_ur = tl_ok && !rx_overflow && !rx_malformed && !rx_poisoned && !rx_is_cpl && rx_unsupported;
	assign ev_ca = tl_ok && !rx_overflow && !rx_malformed && !rx_poisoned && !rx_is_cpl && !rx_unsupported
		&& rx_flash_wr && flash_write_enable_field == pcie_tag_pkg::FWE_WRITES_OFF;
	assign any_expire = |expire;

	// error message selection
	assign ev_corr = (rx_valid && (rx_phy_err || dl_err)) || (dllp_valid && (dllp_phy_err || dllp_bad));
	assign ev_fatal = fc_init_violation || (tl_ok && (rx_overflow || rx_malformed));
	assign ev_nonfatal = any_expire || cpl_poison || cpl_unexp || ev_ur || ev_ca;
	assign ev_log = (tl_ok && !rx_overflow && rx_malformed) || cpl_poison || cpl_unexp || ev_ca;
	assign ev_fc_free = (tl_ok && !rx_overflow && rx_malformed) || cpl_bad;
	assign ev_drop = (rx_valid && (rx_phy_err || rx_dl_err)) || ev_fc_free || cpl_poison || cpl_unexp;

	// in-order release of finished reads
	assign head = oq_reg[rd_ptr_reg];
	assign head_done = done_reg[head];
	assign head_block = block_reg[head];
	assign pop = oq_cnt_reg != 6'h0 && (head_done || head_block);

	// per-client events
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_client
			assign tag_hit[g] = pcie_tag_pkg::client_reads(5'(g)) && rx_tag == pcie_tag_pkg::client_tag(5'(g));
			assign issue_vec[g] = issue && issue_client == 5'(g);
			assign clr_retry[g] = issue_vec[g] && retry_any;
			assign set_done[g] = cpl_good && rx_cpl_last && hit_client == 5'(g);
			assign set_block[g] = cpl_poison && rx_is_cpl && cpl_known && hit_client == 5'(g);
			assign set_retry[g] = expire[g] || (cpl_bad && hit_client == 5'(g));
			assign pop_vec[g] = pop && head == 5'(g);
			assign tmr_start[g] = issue_vec[g] && issue_reads;
			assign tmr_stop[g] = set_done[g] || set_block[g] || cpl_bad && hit_client == 5'(g);
			if (pcie_tag_pkg::client_reads(5'(g))) begin : g_tmr
				ctimer_if tif();
				assign tif.start = tmr_start[g];
				assign tif.stop = tmr_stop[g];
				assign expire[g] = tif.expired;
				completion_timer #(.LIMIT(CPL_TO_CYCLES)) u_tmr (
					.clk_sys(clk_sys),
					.srst(srst),
					.tif(tif)
				);
			end else begin : g_no_tmr
				assign expire[g] = 1'b0;
			end
		end
	endgenerate

	// tracking next state; hardware set beats clear
	assign pend_next = (pend_reg & ~pop_vec) | tmr_start;
	assign done_next = (done_reg & ~pop_vec & ~tmr_start) | set_done;
	assign retry_next = (retry_reg & ~clr_retry & ~pop_vec) | set_retry;
	assign block_next = block_reg | set_block;

	// tracking state
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pend_reg <= '0;
			done_reg <= '0;
			retry_reg <= '0;
			block_reg <= '0;
		end else begin
			pend_reg <= pend_next;
			done_reg <= done_next;
			retry_reg <= retry_next;
			block_reg <= block_next;
		end
	end

	// request order queue
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_ptr_reg <= 5'h0;
			rd_ptr_reg <= 5'h0;
			oq_cnt_reg <= 6'h0;
		end else begin
			if (issue && issue_reads && !retry_any) begin
				oq_reg[wr_ptr_reg] <= issue_client;
				wr_ptr_reg <= (wr_ptr_reg == pcie_tag_pkg::PTR_LAST) ? 5'h0 : wr_ptr_reg + 5'h1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == pcie_tag_pkg::PTR_LAST) ? 5'h0 : rd_ptr_reg + 5'h1;
			end
			oq_cnt_reg <= oq_cnt_reg + 6'(issue && issue_reads && !retry_any) - 6'(pop);
		end
	end

	// outgoing request and release strobes
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tx_valid_reg <= 1'b0;
			tx_retry_reg <= 1'b0;
			tx_tag_reg <= 8'h00;
			deliver_valid_reg <= 1'b0;
			deliver_tag_reg <= 8'h00;
		end else begin
			tx_valid_reg <= issue;
			tx_retry_reg <= retry_any;
			tx_tag_reg <= pcie_tag_pkg::client_tag(issue_client);
			deliver_valid_reg <= pop && head_done && !head_block;
			deliver_tag_reg <= pcie_tag_pkg::client_tag(head);
		end
	end

	// error reporting and receive actions
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			err_corr_reg <= 1'b0;
			err_nonfatal_reg <= 1'b0;
			err_fatal_reg <= 1'b0;
			hdr_log_valid_reg <= 1'b0;
			hdr_log_reg <= '0;
			nak_reg <= 1'b0;
			tlp_drop_reg <= 1'b0;
			dllp_drop_reg <= 1'b0;
			fc_release_reg <= 1'b0;
			cpl_gen_valid_reg <= 1'b0;
			cpl_gen_status_reg <= 3'h0;
		end else begin
			err_corr_reg <= ev_corr;
			err_nonfatal_reg <= ev_nonfatal;
			err_fatal_reg <= ev_fatal;
			hdr_log_valid_reg <= ev_log;
			if (ev_log) begin
				hdr_log_reg <= rx_hdr;
			end
			nak_reg <= rx_valid && (rx_phy_err || rx_dl_err);
			tlp_drop_reg <= ev_drop;
			dllp_drop_reg <= dllp_valid && (dllp_phy_err || dllp_bad);
			fc_release_reg <= ev_fc_free;
			cpl_gen_valid_reg <= ev_ur || ev_ca;
			cpl_gen_status_reg <= ev_ur ? pcie_tag_pkg::CPL_ST_UR : pcie_tag_pkg::CPL_ST_CA;
		end
	end

	// output drive
	assign tx_valid = tx_valid_reg;
	assign tx_tag = tx_tag_reg;
	assign tx_retry = tx_retry_reg;
	assign deliver_valid = deliver_valid_reg;
	assign deliver_tag = deliver_tag_reg;
	assign err_corr = err_corr_reg;
	assign err_nonfatal = err_nonfatal_reg;
	assign err_fatal = err_fatal_reg;
	assign hdr_log_valid = hdr_log_valid_reg;
	assign hdr_log = hdr_log_reg;
	assign nak = nak_reg;
	assign tlp_drop = tlp_drop_reg;
	assign dllp_drop = dllp_drop_reg;
	assign fc_release = fc_release_reg;
	assign cpl_gen_valid = cpl_gen_valid_reg;
	assign cpl_gen_status = cpl_gen_status_reg;
	assign client_blocked = block_reg;

	// checks
	tag_legal_a: assert property (@(posedge clk_sys) disable iff (srst)
		tx_valid |-> tx_tag inside {[8'h00:8'h02], [8'h04:8'h0c], 8'h0e, 8'h10, 8'h11})
		else $error("illegal tag sent");
	tag_map_a: assert property (@(posedge clk_sys) disable iff (srst)
		req_valid && req_ready |=> tx_valid && !tx_retry && tx_tag == pcie_tag_pkg::client_tag($past(req_client)))
		else $error("request tag does not match its client");
	read_pend_a: assert property (@(posedge clk_sys) disable iff (srst)
		issue && issue_reads |=> pend_reg[$past(issue_client)]) else $error("read not tracked");
	timeout_rep_a: assert property (@(posedge clk_sys) disable iff (srst)
		any_expire |=> err_nonfatal ##[1:N] (tx_valid && tx_retry)) else $error("timeout not reported or retried");
	unexp_cpl_a: assert property (@(posedge clk_sys) disable iff (srst)
		cpl_unexp |=> err_nonfatal && hdr_log_valid && tlp_drop && !deliver_valid)
		else $error("unexpected completion kept");
	malformed_a: assert property (@(posedge clk_sys) disable iff (srst)
		tl_ok && !rx_overflow && rx_malformed |=> err_fatal && tlp_drop && fc_release && hdr_log_valid && !cpl_gen_valid)
		else $error("malformed tlp not handled");
	bad_cpl_a: assert property (@(posedge clk_sys) disable iff (srst)
		cpl_bad && !any_expire |=> fc_release && !err_nonfatal && !err_fatal) else $error("unsuccessful completion misreported");
	phy_supp_a: assert property (@(posedge clk_sys) disable iff (srst)
		rx_valid && rx_phy_err |=> err_corr && nak && !hdr_log_valid && !cpl_gen_valid)
		else $error("receiver error not isolated");
	poison_blk_a: assert property (@(posedge clk_sys) disable iff (srst)
		|set_block |=> err_nonfatal && hdr_log_valid && tlp_drop && (block_reg & $past(set_block)) == $past(set_block))
		else $error("poisoned completion not blocked");
	blk_issue_a: assert property (@(posedge clk_sys) disable iff (srst)
		issue |-> !block_reg[issue_client]) else $error("blocked client issued a request");
	flash_ca_a: assert property (@(posedge clk_sys) disable iff (srst)
		ev_ca |=> cpl_gen_valid && cpl_gen_status == pcie_tag_pkg::CPL_ST_CA && hdr_log_valid)
		else $error("completer abort missing");
	order_cnt_a: assert property (@(posedge clk_sys) disable iff (srst)
		deliver_valid |-> $past(oq_cnt_reg) != 6'h0) else $error("release without outstanding read");
	retry_cov_c: cover property (@(posedge clk_sys) disable iff (srst) any_expire ##[1:4] tx_retry);
	order_cov_c: cover property (@(posedge clk_sys) disable iff (srst) cpl_good ##[1:20] deliver_valid);
	block_cov_c: cover property (@(posedge clk_sys) disable iff (srst) |set_block);
endmodule : pcie_request_tag_and_error_handler

// ==== testbench/root_complex_model.sv ====
// model: host completer that answers each read request after a tag dependent delay
`timescale 1ns/1ps
module root_complex_model (
	input wire logic clk_sys,
	input wire logic tx_valid,
	input wire logic [7:0] tx_tag,
	input wire logic [1:0] mode,
	output logic cpl_valid,
	output logic [7:0] cpl_tag,
	output logic cpl_ok,
	output logic cpl_last,
	output logic cpl_poison
);
	logic [11:0] out_q[$];
	logic [11:0] item;
	initial begin
		{cpl_valid, cpl_tag, cpl_ok, cpl_last, cpl_poison} = 12'h000;
	end
	// mode 0 answers in two parts, 1 stays silent, 2 fails, 3 poisons; tags with a low last hex digit wait longest
	task automatic respond(input logic [7:0] tag, input logic [1:0] m);
		repeat (12 - tag[3:0] / 2) @(posedge clk_sys);
		case (m)
			2'h0: begin
				out_q.push_back({4'h4, tag});
				repeat (2) @(posedge clk_sys);
				out_q.push_back({4'h6, tag});
			end
			2'h2: out_q.push_back({4'h2, tag});
			2'h3: out_q.push_back({4'he, tag});
			default: ;
		endcase
	endtask : respond
	// one completion a cycle; released lines show the inverse of their last value
	always @(posedge clk_sys) begin : drive
		logic [7:0] t;
		logic [1:0] m;
		t = tx_tag;
		m = mode;
		if (tx_valid && (t inside {8'h01, 8'h04, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h10})) begin
			fork
				respond(t, m);
			join_none
		end
		#1;
		if (out_q.size() > 0) begin
			item = out_q.pop_front();
			cpl_valid = 1'b1;
			{cpl_poison, cpl_ok, cpl_last} = item[11:9];
			cpl_tag = item[7:0];
		end else begin
			cpl_valid = 1'b0;
			{cpl_poison, cpl_ok, cpl_last, cpl_tag} = ~{cpl_poison, cpl_ok, cpl_last, cpl_tag};
		end
	end
endmodule : root_complex_model

// ==== testbench/tb_top.sv ====
// testbench: drives clients and receive errors, scores tags, deliveries and error actions
`timescale 1ns/1ps
module tb_top;
	localparam int TO = 60;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic req_valid = 1'b0;
	pcie_tag_pkg::client_t req_client = pcie_tag_pkg::CL_RX_DATA;
	logic [11:0] inj = 12'h000;
	logic [1:0] mode = 2'h0;
	logic [127:0] hdr_r = 128'h0;
	logic req_ready, tx_valid, tx_retry, deliver_valid, err_corr, err_nonfatal, err_fatal, hdr_log_valid;
	logic nak, tlp_drop, dllp_drop, fc_release, cpl_gen_valid, m_valid, m_ok, m_last, m_poi;
	logic [7:0] tx_tag, deliver_tag, m_tag;
	logic [2:0] cpl_gen_status;
	logic [127:0] hdr_log;
	logic [16:0] client_blocked;
	int failures = 0;
	int cmp_count = 0;
	int n;
	integer seed;
	logic [8:0] txq[$], dlq[$];
	logic [11:0] evq[$];
	logic [127:0] hq[$];
	logic [7:0] exp_tag [15] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b,
		8'h0c, 8'h0e, 8'h10, 8'h11};
	logic [14:0] is_rd = 15'h2faa; // one bit per client, set where the client reads
	// injected flags: fwe, phy, dl, ovf, mal, poi, uns, fwr, unknown cpl, bad dllp, dllp phy, fc init
	logic [11:0] inj_tab [13] = '{12'h480, 12'h240, 12'h100, 12'h080, 12'h040, 12'h020, 12'h810, 12'h010,
		12'h008, 12'h004, 12'h002, 12'h001, 12'h180};
	// expected: corr, nonfatal, fatal, log, nak, drop, dllp drop, fc release, cpl gen, status
	logic [11:0] exp_tab [13] = '{12'h8c0, 12'h8c0, 12'h200, 12'h350, 12'h540, 12'h409, 12'h50c, 12'h000,
		12'h540, 12'h820, 12'h820, 12'h200, 12'h200};
	// receive side mix of partner completions and injected packets
	wire logic rx_valid = m_valid | (|inj[10:3]);
	wire logic [8:0] ev = {err_corr, err_nonfatal, err_fatal, hdr_log_valid, nak, tlp_drop, dllp_drop, fc_release,
		cpl_gen_valid};
	wire logic [11:0] ev_seen = {ev, cpl_gen_valid ? cpl_gen_status : 3'h0};

	pcie_request_tag_and_error_handler #(.CPL_TO_CYCLES(TO)) dut_u (.clk_sys(clk_sys), .srst(srst),
		.req_valid(req_valid), .req_client(req_client), .req_ready(req_ready), .tx_valid(tx_valid),
		.tx_tag(tx_tag), .tx_retry(tx_retry), .rx_valid(rx_valid), .rx_hdr(hdr_r), .rx_phy_err(inj[10]),
		.rx_dl_err(inj[9]), .rx_overflow(inj[8]), .rx_malformed(inj[7]), .rx_poisoned(m_valid ? m_poi : inj[6]),
		.rx_unsupported(inj[5]), .rx_flash_wr(inj[4]), .rx_is_cpl(m_valid | inj[3]),
		.rx_cpl_ok(m_valid ? m_ok : 1'b1), .rx_cpl_last(m_valid ? m_last : 1'b1),
		.rx_tag(m_valid ? m_tag : 8'h1f), .rx_id_match(m_valid), .flash_write_enable_field(inj[11] ? 2'h2 : 2'h0),
		.dllp_valid(|inj[2:1]), .dllp_phy_err(inj[1]), .dllp_bad(inj[2]), .fc_init_violation(inj[0]),
		.deliver_valid(deliver_valid), .deliver_tag(deliver_tag), .err_corr(err_corr), .err_nonfatal(err_nonfatal),
		.err_fatal(err_fatal), .hdr_log_valid(hdr_log_valid), .hdr_log(hdr_log), .nak(nak), .tlp_drop(tlp_drop),
		.dllp_drop(dllp_drop), .fc_release(fc_release), .cpl_gen_valid(cpl_gen_valid),
		.cpl_gen_status(cpl_gen_status), .client_blocked(client_blocked));

	root_complex_model host_u (.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_tag(tx_tag), .mode(mode),
		.cpl_valid(m_valid), .cpl_tag(m_tag), .cpl_ok(m_ok), .cpl_last(m_last), .cpl_poison(m_poi));

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic chk_tag(input string name, input logic [8:0] e, input logic [8:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask : chk_tag

	task automatic chk_val(input string name, input logic [127:0] e, input logic [127:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask : chk_val

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask : tick

	// hold the request until taken, then note its tag and, for reads, its delivery
	task automatic send_req(input int c);
		req_client = pcie_tag_pkg::client_t'(c);
		req_valid = 1'b1;
		n = 0;
		// ready is looked at mid-cycle where it has settled; the next rising edge takes the request
		do begin
			@(negedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 200);
		if (req_ready !== 1'b1) failures++;
		@(posedge clk_sys);
		#1;
		txq.push_back({1'b0, exp_tag[c]});
		if (is_rd[c]) dlq.push_back({1'b0, exp_tag[c]});
	endtask : send_req

	task automatic drain();
		repeat (400) begin
			if (txq.size() + dlq.size() + evq.size() + hq.size() == 0) break;
			tick();
		end
		repeat (10) tick();
	endtask : drain

	// scoreboard: each result that shows takes the oldest note of its kind
	always @(posedge clk_sys) begin
		if (!srst) begin
			chk_val("strobes_known", 128'h0, {127'h0, $isunknown({tx_valid, deliver_valid, ev, hdr_log_valid})});
			if (tx_valid) chk_tag("tx_tag", txq.size() ? txq.pop_front() : 9'hx, {tx_retry, tx_tag});
			if (deliver_valid) chk_tag("deliver", dlq.size() ? dlq.pop_front() : 9'hx, {1'b0, deliver_tag});
			if (|ev) chk_val("events", evq.size() ? evq.pop_front() : 12'hx, ev_seen);
			if (hdr_log_valid) chk_val("hdr_log", hq.size() ? hq.pop_front() : 128'hx, hdr_log);
		end
	end

	initial begin
		#(20000 * 10);
		failures++;
		test_done();
	end

	initial begin
		seed = 32'h0637;
		repeat (6) @(posedge clk_sys);
		chk_val("ready_in_reset", 128'h0, {127'h0, req_ready});
		#1 srst = 1'b0;
		tick();
		// every client back to back; completions come back split and out of order
		for (int c = 0; c < 15; c++) send_req(c);
		req_valid = 1'b0;
		drain();
		// silent completer: timeout after the limit, non-fatal report and reissue
		mode = 2'h1;
		send_req(13);
		req_valid = 1'b0;
		evq.push_back(12'h400);
		txq.push_back({1'b1, 8'h10});
		tick();
		mode = 2'h0;
		n = 1;
		while (err_nonfatal !== 1'b1 && n < TO + 20) begin
			tick();
			n++;
		end
		chk_val("timeout_span", 128'h1, {127'h0, n >= TO && n <= TO + 3});
		drain();
		// unsuccessful completion: credits freed, no report, read sent again
		mode = 2'h2;
		send_req(3);
		req_valid = 1'b0;
		evq.push_back(12'h050);
		txq.push_back({1'b1, 8'h04});
		tick();
		mode = 2'h0;
		drain();
		// receive error table, one packet at a time
		for (int i = 0; i < 13; i++) begin
			hdr_r = {$random(seed), $random(seed), $random(seed), $random(seed)};
			inj = inj_tab[i];
			if (exp_tab[i] != 12'h000) evq.push_back(exp_tab[i]);
			if (exp_tab[i][8]) hq.push_back(hdr_r);
			tick();
			inj = 12'h000;
			repeat (3) tick();
		end
		drain();
		// poisoned completion blocks its client for good
		hdr_r = {$random(seed), $random(seed), $random(seed), $random(seed)};
		mode = 2'h3;
		send_req(7);
		req_valid = 1'b0;
		dlq.delete(dlq.size() - 1);
		evq.push_back(12'h540);
		hq.push_back(hdr_r);
		tick();
		mode = 2'h0;
		drain();
		chk_val("blocked", 128'h80, {111'h0, client_blocked});
		req_valid = 1'b1;
		repeat (5) tick();
		chk_val("ready_blocked", 128'h0, {127'h0, req_ready});
		req_valid = 1'b0;
		drain();
		chk_val("notes_left", 128'h0, txq.size() + dlq.size() + evq.size() + hq.size());
		test_done();
	end
endmodule : tb_top
